// file: bench/host_bus_model.sv
// isa host bus model with its configuration software
module host_bus_model (
  // clock and card side of the data lines
  input  wire logic       clk_i,
  input  wire logic [7:0] card_d_i,
  input  wire logic       card_oe_n_i,
  // host strobes, index and data wire
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic            aport_o,
  output logic [7:0]      idx_o,
  output logic [7:0]      wire_o,
  output logic [7:0]      rd_val_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv;
  // card drives during its read, else host or another card
  assign wire_o = (card_oe_n_i === 1'b0) ? card_d_i : drv;
  // idle bus
  initial
  begin
    drv = 8'h00;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    aport_o = 1'b0;
    idx_o = 8'h00;
    rd_val_o = 8'h00;
  end
  task automatic wr(input logic a, input logic [7:0] i, input logic [7:0] d);
    @(negedge clk_i);
    aport_o = a;
    idx_o = i;
    drv = d;
    @(negedge clk_i);
    wr_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    wr_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
    drv = ~d;
  endtask
  // read; oth is what another card shows on the wire
  task automatic rd(input logic [7:0] i, input logic [7:0] oth);
    @(negedge clk_i);
    aport_o = 1'b0;
    idx_o = i;
    drv = oth;
    @(negedge clk_i);
    rd_n_o = 1'b0;
    repeat (5) @(negedge clk_i);
    rd_val_o = wire_o;
    rd_n_o = 1'b1;
    repeat (5) @(negedge clk_i);
    drv = ~oth;
  endtask
  task automatic key();
    logic [7:0] v;
    v = pnp_cfg_pkg::KEY_SEED;
    repeat (pnp_cfg_pkg::KEY_LEN)
    begin
      wr(1'b1, 8'h00, v);
      v = {v[1] ^ v[0], v[7:1]};
    end
  endtask
endmodule

// file: bench/pnp_isa_config_and_routing_tb.sv
// self-checking bench for the configuration and routing block
module pnp_isa_config_and_routing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int k; logic [7:0] e; logic [7:0] m;} note_t;
  note_t notes[$];
  event got;
  int mismatches = 0;
  int total_checks = 0;
  int seed = 99459;
  logic clk = 0;
  logic rst = 1;
  logic [15:0] pa = '0;
  logic pw = 0;
  logic [7:0] pd = '0;
  logic [7:0] rdat, hdo, hwire, idx, hval;
  logic irq, wr_n, rd_n, aport, hoe_n;
  logic uirq = 0, rqa = 0, rqb = 0, hka = 1, hkb = 1;
  wire [7:0] pv;
  string nm[4] = '{"rdata", "pins", "host read", "proc irq"};
  // clock
  always #5 clk = ~clk;
  pnp_isa_config_and_routing DUT (
    .CORE_CLK_I(clk), .RESET_I(rst), .PROC_ADDR_I(pa), .PROC_WR_I(pw),
    .PROC_WDATA_I(pd), .PROC_RDATA_O(rdat), .PROC_IRQ_O(irq),
    .HOST_WR_N_I(wr_n), .HOST_RD_N_I(rd_n), .HOST_ADDR_PORT_I(aport),
    .HOST_INDEX_I(idx), .HOST_DATA_I(hwire), .HOST_DATA_O(hdo),
    .HOST_DATA_OE_N_O(hoe_n), .UART_EMUL_IRQ_I(uirq),
    .HOST_IRQ_PIN_A_O(pv[7]), .HOST_IRQ_PIN_B_O(pv[6]),
    .DMA_REQ_A_I(rqa), .DMA_REQ_B_I(rqb), .DMA_ACK_A_O(pv[1]),
    .DMA_ACK_B_O(pv[0]), .HOST_DMA_REQ_A_O(pv[5]),
    .HOST_DMA_REQ_A_OE_N_O(pv[4]), .HOST_DMA_REQ_B_O(pv[3]),
    .HOST_DMA_REQ_B_OE_N_O(pv[2]), .HOST_DMA_ACK_A_N_I(hka),
    .HOST_DMA_ACK_B_N_I(hkb));
  host_bus_model host (
    .clk_i(clk), .card_d_i(hdo), .card_oe_n_i(hoe_n), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .aport_o(aport), .idx_o(idx), .wire_o(hwire),
    .rd_val_o(hval));
  task automatic cmp(input string w, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask
  task automatic note(input int k, input logic [7:0] e, input logic [7:0] m);
    notes.push_back('{k, e, m});
    -> got;
    #1;
  endtask
  task automatic pwr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    pa = a;
    pd = d;
    pw = 1;
    @(negedge clk);
    pw = 0;
  endtask
  task automatic prd(input logic [15:0] a, input logic [7:0] e, m);
    @(negedge clk);
    pa = a;
    repeat (2) @(negedge clk);
    note(0, e, m);
  endtask
  task automatic pins(input logic [7:0] e, m);
    repeat (4) @(negedge clk);
    note(1, e, m);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // take the oldest note whenever a result is due
  always @(got)
  begin
    note_t n;
    logic [7:0] s;
    n = notes.pop_front();
    case (n.k)
      0: s = rdat;
      1: s = pv;
      2: s = hval;
      default: s = {7'h00, irq};
    endcase
    cmp(nm[n.k], n.e & n.m, s & n.m);
  end
  // watchdog
  initial
  begin
    #60000;
    mismatches++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 0;
    prd(pnp_cfg_pkg::P_MASTER, 8'h20, 8'hFF);
    prd(pnp_cfg_pkg::P_DMA1, 8'h04, 8'h07);
    pins(8'h14, 8'hFF);
    $display("reset test done");
    pwr(pnp_cfg_pkg::P_IRQ, 8'h33);
    uirq = 1;
    pins(8'h94, 8'hFF);
    pwr(pnp_cfg_pkg::P_IRQ, 8'h53);
    pins(8'h54, 8'hFF);
    pwr(pnp_cfg_pkg::P_IRQ, 8'h50);
    pins(8'h14, 8'hFF);
    pwr(pnp_cfg_pkg::P_IRQ, 8'h33);
    pwr(pnp_cfg_pkg::P_DMA0, 8'h01);
    pwr(pnp_cfg_pkg::P_DMA1, 8'h02);
    repeat (8)
    begin
      {rqa, rqb, hka, hkb} = 4'($random(seed));
      pins({2'b10, rqa, 1'b0, rqb, 1'b0, ~hka, ~hkb}, 8'hFF);
    end
    pwr(pnp_cfg_pkg::P_DMA0, 8'h04);
    pwr(pnp_cfg_pkg::P_DMA1, 8'h04);
    {uirq, rqa, rqb, hka, hkb} = 5'h03;
    $display("routing test done");
    host.wr(1'b1, 8'h00, pnp_cfg_pkg::KEY_SEED);
    host.wr(1'b1, 8'h00, 8'h00);
    host.key();
    prd(pnp_cfg_pkg::P_MASTER, 8'h01, 8'h03);
    host.wr(1'b0, pnp_cfg_pkg::H_WAKE, 8'h00);
    prd(pnp_cfg_pkg::P_MASTER, 8'h36, 8'hFF);
    pwr(pnp_cfg_pkg::P_MASTER, 8'h3C);
    host.rd(pnp_cfg_pkg::H_ISO, 8'h01);
    note(2, 8'h01, 8'hFF);
    host.rd(pnp_cfg_pkg::H_ISO, 8'h02);
    prd(pnp_cfg_pkg::P_MASTER, 8'h0D, 8'hFF);
    pwr(pnp_cfg_pkg::P_MASTER, 8'h84);
    note(3, 8'h00, 8'h01);
    host.wr(1'b0, pnp_cfg_pkg::H_WAKE, 8'h00);
    pwr(pnp_cfg_pkg::P_MASTER, 8'h80);
    note(3, 8'h01, 8'h01);
    pwr(pnp_cfg_pkg::P_MASTER, 8'h7C);
    host.rd(pnp_cfg_pkg::H_ISO, 8'hFF);
    note(2, 8'h55, 8'hFF);
    host.rd(pnp_cfg_pkg::H_ISO, 8'hFF);
    note(2, 8'hAA, 8'hFF);
    host.wr(1'b0, pnp_cfg_pkg::H_SNUM, 8'h05);
    prd(pnp_cfg_pkg::P_MASTER, 8'h0F, 8'hFF);
    pwr(pnp_cfg_pkg::P_DMA0, 8'h01);
    prd(pnp_cfg_pkg::P_DMA0, 8'h04, 8'h07);
    host.wr(1'b0, pnp_cfg_pkg::H_IRQ, 8'h05);
    host.rd(pnp_cfg_pkg::H_IRQ, 8'hFF);
    note(2, 8'h05, 8'hFF);
    uirq = 1;
    pins(8'h54, 8'hF6);
    host.wr(1'b0, pnp_cfg_pkg::H_IRQ, 8'h03);
    host.wr(1'b0, pnp_cfg_pkg::H_DMA0, 8'h01);
    {rqa, hka} = 2'b10;
    pins(8'hA6, 8'hF6);
    $display("isolation test done");
    pwr(pnp_cfg_pkg::P_MASTER, 8'h3C);
    host.wr(1'b0, pnp_cfg_pkg::H_WAKE, 8'h07);
    prd(pnp_cfg_pkg::P_MASTER, 8'h05, 8'h07);
    pwr(pnp_cfg_pkg::P_IRQ, 8'h73);
    prd(pnp_cfg_pkg::P_IRQ, 8'h33, 8'hFF);
    host.wr(1'b0, pnp_cfg_pkg::H_CTRL, 8'h02);
    prd(pnp_cfg_pkg::P_MASTER, 8'h00, 8'h03);
    host.wr(1'b0, pnp_cfg_pkg::H_CTRL, 8'h04);
    prd(pnp_cfg_pkg::P_SNUM, 8'h00, 8'hFF);
    pwr(pnp_cfg_pkg::P_MASTER, 8'h3C);
    host.wr(1'b0, pnp_cfg_pkg::H_CTRL, 8'h01);
    prd(pnp_cfg_pkg::P_MASTER, 8'h24, 8'h3C);
    $display("control test done");
    wrap_up();
  end
endmodule

// file: core/init_key_detect.sv
// initiation key detector on host address-port writes
module init_key_detect #(
  parameter int LEN = pnp_cfg_pkg::KEY_LEN
) (
  // clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       RESET_I,
  // address-port write strobe and data
  input  wire logic       key_wr_i,
  input  wire logic [7:0] key_data_i,
  // whole key seen, one-cycle pulse
  output logic            key_found_o
);
  typedef struct packed {
    logic [7:0] expect_byte;
    logic [5:0] count;
    logic       found;
  } key_reg_t;

  key_reg_t r;
  key_reg_t next_r;

  // compare each write against the expected key byte
  always_comb
  begin
    next_r = r;
    next_r.found = 1'b0;
    if (key_wr_i)
    begin
      if (key_data_i == r.expect_byte)
      begin
        if (r.count == 6'(LEN - 1))
        begin
          next_r.found = 1'b1;
          next_r.expect_byte = pnp_cfg_pkg::KEY_SEED;
          next_r.count = 6'h00;
        end
        else
        begin
          next_r.expect_byte = pnp_cfg_pkg::key_next(r.expect_byte);
          next_r.count = r.count + 6'h01;
        end
      end
      else if (key_data_i == pnp_cfg_pkg::KEY_SEED)
      begin
        next_r.expect_byte = pnp_cfg_pkg::key_next(key_data_i);
        next_r.count = 6'h01;
      end
      else
      begin
        next_r.expect_byte = pnp_cfg_pkg::KEY_SEED;
        next_r.count = 6'h00;
      end
    end
    if (RESET_I)
    begin
      next_r = '0;
      next_r.expect_byte = pnp_cfg_pkg::KEY_SEED;
    end
  end

  // state register
  always_ff @(posedge CORE_CLK_I)
    r <= next_r;

  assign key_found_o = r.found;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);

  a_key_restart: assert property (
    key_wr_i && key_data_i != r.expect_byte
      && key_data_i != pnp_cfg_pkg::KEY_SEED
    |=> r.count == 6'h00 && !r.found)
    else $error("key detector did not restart on mismatch");
endmodule

// file: core/pnp_cfg_pkg.sv
// constants and types shared by the plug-and-play configuration block
package pnp_cfg_pkg;
  // processor-side register addresses
  localparam logic [15:0] P_MASTER = 16'h0102;
  localparam logic [15:0] P_SNUM   = 16'h0106;
  localparam logic [15:0] P_IRQ    = 16'h0170;
  localparam logic [15:0] P_DMA0   = 16'h0174;
  localparam logic [15:0] P_DMA1   = 16'h0175;
  // host-side configuration indices
  localparam logic [7:0]  H_ISO    = 8'h01;
  localparam logic [7:0]  H_CTRL   = 8'h02;
  localparam logic [7:0]  H_WAKE   = 8'h03;
  localparam logic [7:0]  H_RDATA  = 8'h04;
  localparam logic [7:0]  H_SNUM   = 8'h06;
  localparam logic [7:0]  H_IRQ    = 8'h70;
  localparam logic [7:0]  H_DMA0   = 8'h74;
  localparam logic [7:0]  H_DMA1   = 8'h75;
  // master register bit positions
  localparam int MR_IE    = 7;
  localparam int MR_ISO   = 6;
  localparam int MR_SRST  = 5;
  localparam int MR_WAKE  = 4;
  localparam int MR_IREAD = 3;
  localparam int MR_PEND  = 2;
  // configuration control bit positions
  localparam int CC_SRST  = 0;
  localparam int CC_WFK   = 1;
  localparam int CC_SNUM  = 2;
  // reset values
  localparam logic [7:0] MASTER_RST = 8'h20;
  localparam logic [7:0] SNUM_RST   = 8'h00;
  localparam logic [3:0] IRQ_RST    = 4'h0;
  localparam logic [2:0] DMA0_RST   = 3'h4;
  localparam logic [2:0] DMA1_RST   = 3'h4;
  // dma channel code meaning not routed
  localparam logic [2:0] DMA_OFF    = 3'h4;
  // isolation read patterns
  localparam logic [1:0] ISO_FIRST  = 2'h1;
  localparam logic [1:0] ISO_SECOND = 2'h2;
  localparam logic [7:0] ISO_DRV_A  = 8'h55;
  localparam logic [7:0] ISO_DRV_B  = 8'hAA;
  // initiation key
  localparam logic [7:0] KEY_SEED   = 8'h6A;
  localparam int         KEY_LEN    = 32;

  // configuration states, coded 00 to 11 in order
  typedef enum logic [1:0] {
    ST_WAIT_KEY,
    ST_SLEEP,
    ST_ISOLATE,
    ST_CONFIG
  } cfg_state_t;

  // next byte of the initiation key sequence
  function automatic logic [7:0] key_next(input logic [7:0] v);
    key_next = {v[1] ^ v[0], v[7:1]};
  endfunction
endpackage

// file: core/pnp_isa_config_and_routing.sv
// plug-and-play configuration state, flags and host pin routing

// Summary of operation
// - uart irq drives pin a if shadow equals level, pin b if differs and nonzero
// - after host configures irq level, shadow writes blocked; host reads zero
// - non-plug-and-play use keeps shadow equal level, so pin a is used
// - irq and dma registers read-only to processor in configured state
// - mailbox zero routed to dma pins a unless code 100; then float request
// - mailbox one routed to dma pins b unless code 100; then float request
// - processor interrupt while enable and pending are both one
// - software reset flag set by reset or host control bit 0
// - wake-match flag set by wake write equal to card-select number
// - isolation-read flag set at end of second isolation read in state 10
// - pending set by the listed host configuration events
// - state field read-only, 00 wait, 01 sleep, 10 isolate, 11 configured
// - reset or control bit 1 goes to 00; key goes 00 to 01
// - wake zero with number zero goes 01 to 10; nonzero match goes 11
// - losing isolation pattern 01 then 10 with bit zero returns to 01
// - card-select write in 10 goes 11; mismatching wake in 1x goes 01
// - wake write only compares host data, nothing stored
// - card-select number resets to 00 and clears on control bit 2
module pnp_isa_config_and_routing (
  // clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_I,
  // processor register port
  input  wire logic [15:0] PROC_ADDR_I,
  input  wire logic        PROC_WR_I,
  input  wire logic [7:0]  PROC_WDATA_I,
  output logic      [7:0]  PROC_RDATA_O,
  output logic             PROC_IRQ_O,
  // host configuration pins
  input  wire logic        HOST_WR_N_I,
  input  wire logic        HOST_RD_N_I,
  input  wire logic        HOST_ADDR_PORT_I,
  input  wire logic [7:0]  HOST_INDEX_I,
  input  wire logic [7:0]  HOST_DATA_I,
  output logic      [7:0]  HOST_DATA_O,
  output logic             HOST_DATA_OE_N_O,
  // interrupt routing
  input  wire logic        UART_EMUL_IRQ_I,
  output logic             HOST_IRQ_PIN_A_O,
  output logic             HOST_IRQ_PIN_B_O,
  // dma mailbox side
  input  wire logic        DMA_REQ_A_I,
  input  wire logic        DMA_REQ_B_I,
  output logic             DMA_ACK_A_O,
  output logic             DMA_ACK_B_O,
  // host dma pins
  output logic             HOST_DMA_REQ_A_O,
  output logic             HOST_DMA_REQ_A_OE_N_O,
  output logic             HOST_DMA_REQ_B_O,
  output logic             HOST_DMA_REQ_B_OE_N_O,
  input  wire logic        HOST_DMA_ACK_A_N_I,
  input  wire logic        HOST_DMA_ACK_B_N_I
);
  typedef struct packed {
    logic [2:0]             wr_s;
    logic [2:0]             rd_s;
    logic [1:0]             port_s;
    logic [7:0]             idx_s1;
    logic [7:0]             idx_s2;
    logic [7:0]             dat_s1;
    logic [7:0]             dat_s2;
    logic [1:0]             ack_a_s;
    logic [1:0]             ack_b_s;
    pnp_cfg_pkg::cfg_state_t state;
    logic                   ie;
    logic                   iso_bit;
    logic                   srst;
    logic                   wake_flag;
    logic                   iread_flag;
    logic                   pend;
    logic [7:0]             sel_num;
    logic [3:0]             irq_level;
    logic [3:0]             irq_shadow;
    logic                   irq_locked;
    logic [2:0]             dma0;
    logic [2:0]             dma1;
    logic                   iso_phase;
    logic [1:0]             iso_first;
    logic [7:0]             proc_rdata;
    logic [7:0]             host_dout;
    logic                   host_drive;
    logic                   irq_a;
    logic                   irq_b;
    logic                   req_a;
    logic                   req_a_en;
    logic                   req_b;
    logic                   req_b_en;
    logic                   ack_a;
    logic                   ack_b;
  } cfg_reg_t;

  cfg_reg_t r;
  cfg_reg_t next_r;
  logic     wr_rise;
  logic     rd_fall;
  logic     hw;
  logic     kw;
  logic     iso_rd_end;
  logic     wake_hit;
  logic     key_found;
  logic     in_cfg;
  logic     p_wr_irq;

  // host strobe edges, taken from the synchronised copies
  assign wr_rise    = r.wr_s[1] & ~r.wr_s[2];
  assign rd_fall    = ~r.rd_s[1] & r.rd_s[2];
  assign hw         = wr_rise & ~r.port_s[1];
  assign kw         = wr_rise & r.port_s[1];
  assign iso_rd_end = rd_fall && r.idx_s2 == pnp_cfg_pkg::H_ISO
                      && r.state == pnp_cfg_pkg::ST_ISOLATE;
  // wake data is only compared, never stored
  assign wake_hit   = r.dat_s2 == r.sel_num;
  assign in_cfg     = r.state == pnp_cfg_pkg::ST_CONFIG;
  assign p_wr_irq   = PROC_WR_I && PROC_ADDR_I == pnp_cfg_pkg::P_IRQ;

  // initiation key detector on address-port writes
  init_key_detect #(
    .LEN (pnp_cfg_pkg::KEY_LEN)
  ) u_key (
    .CORE_CLK_I  (CORE_CLK_I),
    .RESET_I     (RESET_I),
    .key_wr_i    (kw),
    .key_data_i  (r.dat_s2),
    .key_found_o (key_found)
  );

  // next state: synchronisers, processor writes, host events, outputs
  always_comb
  begin
    next_r = r;
    next_r.wr_s    = {r.wr_s[1:0], ~HOST_WR_N_I};
    next_r.rd_s    = {r.rd_s[1:0], ~HOST_RD_N_I};
    next_r.port_s  = {r.port_s[0], HOST_ADDR_PORT_I};
    next_r.idx_s1  = HOST_INDEX_I;
    next_r.idx_s2  = r.idx_s1;
    next_r.dat_s1  = HOST_DATA_I;
    next_r.dat_s2  = r.dat_s1;
    next_r.ack_a_s = {r.ack_a_s[0], ~HOST_DMA_ACK_A_N_I};
    next_r.ack_b_s = {r.ack_b_s[0], ~HOST_DMA_ACK_B_N_I};

    // processor writes; flags are write-one-to-clear
    if (PROC_WR_I && PROC_ADDR_I == pnp_cfg_pkg::P_MASTER)
    begin
      next_r.ie      = PROC_WDATA_I[pnp_cfg_pkg::MR_IE];
      next_r.iso_bit = PROC_WDATA_I[pnp_cfg_pkg::MR_ISO];
      if (PROC_WDATA_I[pnp_cfg_pkg::MR_SRST])
        next_r.srst = 1'b0;
      if (PROC_WDATA_I[pnp_cfg_pkg::MR_WAKE])
        next_r.wake_flag = 1'b0;
      if (PROC_WDATA_I[pnp_cfg_pkg::MR_IREAD])
        next_r.iread_flag = 1'b0;
      if (PROC_WDATA_I[pnp_cfg_pkg::MR_PEND])
        next_r.pend = 1'b0;
    end
    // processor locked out of irq and dma while configured
    if (!in_cfg)
    begin
      if (p_wr_irq)
      begin
        next_r.irq_level = PROC_WDATA_I[3:0];
        // shadow frozen once the host has configured it
        if (!r.irq_locked)
          next_r.irq_shadow = PROC_WDATA_I[7:4];
      end
      if (PROC_WR_I && PROC_ADDR_I == pnp_cfg_pkg::P_DMA0)
        next_r.dma0 = PROC_WDATA_I[2:0];
      if (PROC_WR_I && PROC_ADDR_I == pnp_cfg_pkg::P_DMA1)
        next_r.dma1 = PROC_WDATA_I[2:0];
    end

    if (key_found && r.state == pnp_cfg_pkg::ST_WAIT_KEY)
      next_r.state = pnp_cfg_pkg::ST_SLEEP;

    // host wake write
    if (hw && r.idx_s2 == pnp_cfg_pkg::H_WAKE)
    begin
      next_r.iso_phase = 1'b0;
      // wake match flag; pending on match or 1x mismatch
      if (wake_hit)
      begin
        next_r.wake_flag = 1'b1;
        next_r.pend = 1'b1;
      end
      else if (r.state[1])
        next_r.pend = 1'b1;
      case (r.state)
        pnp_cfg_pkg::ST_SLEEP:
        begin
          if (r.dat_s2 == 8'h00 && r.sel_num == 8'h00)
            next_r.state = pnp_cfg_pkg::ST_ISOLATE;
          else if (r.dat_s2 != 8'h00 && wake_hit)
            next_r.state = pnp_cfg_pkg::ST_CONFIG;
        end
        pnp_cfg_pkg::ST_ISOLATE,
        pnp_cfg_pkg::ST_CONFIG:
        begin
          // mismatching wake sends back to sleep
          if (!wake_hit)
            next_r.state = pnp_cfg_pkg::ST_SLEEP;
        end
        default:
        begin
        end
      endcase
    end

    if (hw && r.idx_s2 == pnp_cfg_pkg::H_SNUM && r.state[1])
    begin
      next_r.sel_num = r.dat_s2;
      next_r.pend = 1'b1;
      if (r.state == pnp_cfg_pkg::ST_ISOLATE)
        next_r.state = pnp_cfg_pkg::ST_CONFIG;
    end

    // host configures irq level and dma channels
    if (hw && in_cfg)
    begin
      if (r.idx_s2 == pnp_cfg_pkg::H_IRQ)
      begin
        next_r.irq_level  = r.dat_s2[3:0];
        next_r.irq_locked = 1'b1;
      end
      if (r.idx_s2 == pnp_cfg_pkg::H_DMA0)
        next_r.dma0 = r.dat_s2[2:0];
      if (r.idx_s2 == pnp_cfg_pkg::H_DMA1)
        next_r.dma1 = r.dat_s2[2:0];
    end

    if (rd_fall && in_cfg && r.idx_s2 == pnp_cfg_pkg::H_RDATA)
      next_r.pend = 1'b1;

    // isolation reads come in pairs per identifier bit
    if (iso_rd_end)
    begin
      next_r.iso_phase = ~r.iso_phase;
      if (!r.iso_phase)
        next_r.iso_first = r.dat_s2[1:0];
      else
      begin
        // isolation read flag on second read
        next_r.iread_flag = 1'b1;
        next_r.pend = 1'b1;
        if (!r.iso_bit && r.iso_first == pnp_cfg_pkg::ISO_FIRST
            && r.dat_s2[1:0] == pnp_cfg_pkg::ISO_SECOND)
          next_r.state = pnp_cfg_pkg::ST_SLEEP;
      end
    end

    // configuration control write
    if (hw && r.idx_s2 == pnp_cfg_pkg::H_CTRL)
    begin
      next_r.pend = 1'b1;
      if (r.dat_s2[pnp_cfg_pkg::CC_SRST])
      begin
        next_r.srst = 1'b1;
        next_r.irq_locked = 1'b0;
      end
      if (r.dat_s2[pnp_cfg_pkg::CC_WFK])
      begin
        next_r.state = pnp_cfg_pkg::ST_WAIT_KEY;
        next_r.iso_phase = 1'b0;
      end
      if (r.dat_s2[pnp_cfg_pkg::CC_SNUM])
        next_r.sel_num = 8'h00;
    end

    // processor read data; state field only readable
    case (PROC_ADDR_I)
      pnp_cfg_pkg::P_MASTER: next_r.proc_rdata = {r.ie, 1'b0, r.srst,
        r.wake_flag, r.iread_flag, r.pend, r.state};
      pnp_cfg_pkg::P_SNUM:   next_r.proc_rdata = r.sel_num;
      pnp_cfg_pkg::P_IRQ:    next_r.proc_rdata = {r.irq_shadow, r.irq_level};
      pnp_cfg_pkg::P_DMA0:   next_r.proc_rdata = {5'h00, r.dma0};
      pnp_cfg_pkg::P_DMA1:   next_r.proc_rdata = {5'h00, r.dma1};
      default:               next_r.proc_rdata = 8'h00;
    endcase

    // host read data; shadow reads back as zero
    next_r.host_drive = 1'b0;
    next_r.host_dout  = 8'h00;
    case (r.idx_s2)
      pnp_cfg_pkg::H_SNUM:  next_r.host_dout = r.sel_num;
      pnp_cfg_pkg::H_IRQ:   next_r.host_dout = {4'h0, r.irq_level};
      pnp_cfg_pkg::H_DMA0:  next_r.host_dout = {5'h00, r.dma0};
      pnp_cfg_pkg::H_DMA1:  next_r.host_dout = {5'h00, r.dma1};
      pnp_cfg_pkg::H_ISO:   next_r.host_dout = r.iso_phase ?
        pnp_cfg_pkg::ISO_DRV_B : pnp_cfg_pkg::ISO_DRV_A;
      default:              next_r.host_dout = 8'h00;
    endcase
    if (r.rd_s[1] && !r.port_s[1])
    begin
      if (in_cfg && (r.idx_s2 == pnp_cfg_pkg::H_SNUM
          || r.idx_s2 == pnp_cfg_pkg::H_IRQ
          || r.idx_s2 == pnp_cfg_pkg::H_DMA0
          || r.idx_s2 == pnp_cfg_pkg::H_DMA1
          || r.idx_s2 == pnp_cfg_pkg::H_RDATA))
        next_r.host_drive = 1'b1;
      if (r.state == pnp_cfg_pkg::ST_ISOLATE && r.iso_bit
          && r.idx_s2 == pnp_cfg_pkg::H_ISO)
        next_r.host_drive = 1'b1;
    end

    // route uart interrupt by comparing shadow and level
    next_r.irq_a = UART_EMUL_IRQ_I && r.irq_shadow == r.irq_level;
    next_r.irq_b = UART_EMUL_IRQ_I && r.irq_level != 4'h0
                   && r.irq_shadow != r.irq_level;
    next_r.req_a_en = r.dma0 != pnp_cfg_pkg::DMA_OFF;
    next_r.req_a    = DMA_REQ_A_I && r.dma0 != pnp_cfg_pkg::DMA_OFF;
    next_r.ack_a    = r.ack_a_s[1] && r.dma0 != pnp_cfg_pkg::DMA_OFF;
    next_r.req_b_en = r.dma1 != pnp_cfg_pkg::DMA_OFF;
    next_r.req_b    = DMA_REQ_B_I && r.dma1 != pnp_cfg_pkg::DMA_OFF;
    next_r.ack_b    = r.ack_b_s[1] && r.dma1 != pnp_cfg_pkg::DMA_OFF;

    // synchronous reset; card-select number starts at zero
    if (RESET_I)
    begin
      next_r = '0;
      next_r.srst  = pnp_cfg_pkg::MASTER_RST[pnp_cfg_pkg::MR_SRST];
      next_r.sel_num = pnp_cfg_pkg::SNUM_RST;
      next_r.irq_level  = pnp_cfg_pkg::IRQ_RST;
      next_r.irq_shadow = pnp_cfg_pkg::IRQ_RST;
      next_r.dma0  = pnp_cfg_pkg::DMA0_RST;
      next_r.dma1  = pnp_cfg_pkg::DMA1_RST;
      next_r.state = pnp_cfg_pkg::ST_WAIT_KEY;
    end
  end

  // state register
  always_ff @(posedge CORE_CLK_I)
    r <= next_r;

  // outputs, all from flip-flops except the processor interrupt
  assign PROC_RDATA_O          = r.proc_rdata;
  // interrupt request when enabled and pending
  assign PROC_IRQ_O            = r.ie & r.pend;
  assign HOST_DATA_O           = r.host_dout;
  assign HOST_DATA_OE_N_O      = ~r.host_drive;
  assign HOST_IRQ_PIN_A_O      = r.irq_a;
  assign HOST_IRQ_PIN_B_O      = r.irq_b;
  assign HOST_DMA_REQ_A_O      = r.req_a;
  assign HOST_DMA_REQ_A_OE_N_O = ~r.req_a_en;
  assign HOST_DMA_REQ_B_O      = r.req_b;
  assign HOST_DMA_REQ_B_OE_N_O = ~r.req_b_en;
  assign DMA_ACK_A_O           = r.ack_a;
  assign DMA_ACK_B_O           = r.ack_b;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_iso_second;
    iso_rd_end && r.iso_phase && !wr_rise;
  endsequence

  sequence s_iso_lost;
    !r.iso_bit && r.iso_first == pnp_cfg_pkg::ISO_FIRST
      && r.dat_s2[1:0] == pnp_cfg_pkg::ISO_SECOND;
  endsequence

  a_irq_pin_a: assert property (
    UART_EMUL_IRQ_I && r.irq_shadow == r.irq_level && !p_wr_irq && !hw
    |=> HOST_IRQ_PIN_A_O && !HOST_IRQ_PIN_B_O)
    else $error("uart irq not routed to pin a");
  a_irq_pin_b: assert property (
    UART_EMUL_IRQ_I && r.irq_level != 4'h0 && r.irq_shadow != r.irq_level
      && !p_wr_irq && !hw
    |=> HOST_IRQ_PIN_B_O && !HOST_IRQ_PIN_A_O)
    else $error("uart irq not routed to pin b");
  a_shadow_lock: assert property (
    r.irq_locked && !r.srst |=> $stable(r.irq_shadow))
    else $error("shadow nibble changed after host configured it");
  a_cfg_read_only: assert property (
    in_cfg && PROC_WR_I && PROC_ADDR_I == pnp_cfg_pkg::P_DMA0 && !hw
    |=> $stable(r.dma0))
    else $error("processor wrote dma channel while configured");
  a_dma_a_float: assert property (
    r.dma0 == pnp_cfg_pkg::DMA_OFF |=> HOST_DMA_REQ_A_OE_N_O && !DMA_ACK_A_O)
    else $error("dma pin a driven while unassigned");
  a_dma_b_route: assert property (
    r.dma1 != pnp_cfg_pkg::DMA_OFF && DMA_REQ_B_I
    |=> !HOST_DMA_REQ_B_OE_N_O && HOST_DMA_REQ_B_O)
    else $error("dma request b not routed");
  a_proc_irq_req: assert property (
    PROC_WR_I && PROC_ADDR_I == pnp_cfg_pkg::P_MASTER
      && PROC_WDATA_I[pnp_cfg_pkg::MR_IE] && r.pend
      && !PROC_WDATA_I[pnp_cfg_pkg::MR_PEND]
    |=> PROC_IRQ_O)
    else $error("processor interrupt not requested");
  a_soft_reset: assert property (
    hw && r.idx_s2 == pnp_cfg_pkg::H_CTRL && r.dat_s2[pnp_cfg_pkg::CC_SRST]
    |=> r.srst && r.pend ##1 r.srst || $past(PROC_WR_I))
    else $error("software reset flag not set");
  a_wake_match: assert property (
    hw && r.idx_s2 == pnp_cfg_pkg::H_WAKE && wake_hit |=> r.wake_flag && r.pend)
    else $error("wake match flag not set");
  a_iso_lose: assert property (
    s_iso_second ##0 s_iso_lost |=> r.state == pnp_cfg_pkg::ST_SLEEP
      && r.iread_flag)
    else $error("losing isolation did not return to sleep");
  a_wfk_return: assert property (
    hw && r.idx_s2 == pnp_cfg_pkg::H_CTRL && r.dat_s2[pnp_cfg_pkg::CC_WFK]
    |=> r.state == pnp_cfg_pkg::ST_WAIT_KEY)
    else $error("control bit 1 did not return to wait-for-key");
endmodule
